// ### dv/haptic_drive_clamp_timing_tb_top.sv
`timescale 1ns/1ns
module haptic_drive_clamp_timing_tb_top
  import clamp_timing_pkg::*;
;
  localparam int unsigned STEP = 4;
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] mask;
  } note_t;

  logic             clk_sys;
  logic             reset;
  logic [7:0]       address;
  logic             read;
  logic             write;
  logic [31:0]      writedata;
  logic [3:0]       byteenable;
  logic [31:0]      readdata;
  logic             waitrequest;
  clamp_cond_t      cond;
  logic             drive_start;
  logic             bemf_valid;
  logic             actuator_present;
  logic             resonance_update;
  logic [CNT_W-1:0] resonance_period;
  logic [7:0]       effective_limit;
  logic [CNT_W-1:0] drive_period;
  logic [CNT_W-1:0] resync_interval;
  logic             drive_tick;
  logic             tracking;
  note_t            expq[$];
  int               errors;
  int               n_compared;
  int               cycles;

  // Small step and resync counts keep the run short
  haptic_drive_clamp_timing #(
    .STEP_CYCLES(STEP), .RESYNC_HIGH(40), .RESYNC_LOW(90), .BASE_OD_RESET(BASE_OD_RST)
  ) uut (
    .clk_sys(clk_sys), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .overdrive_phase(cond.overdrive_phase),
    .battery_threshold_one(cond.battery_threshold_one),
    .battery_threshold_two(cond.battery_threshold_two),
    .calibration_active(cond.calibration_active), .diagnostic_active(cond.diagnostic_active),
    .drive_start(drive_start), .bemf_valid(bemf_valid), .actuator_present(actuator_present),
    .resonance_update(resonance_update), .resonance_period(resonance_period),
    .effective_limit(effective_limit), .drive_period(drive_period),
    .resync_interval(resync_interval), .drive_tick(drive_tick), .tracking(tracking)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop;
    $display("compared %0d, wrong %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic fail(input string msg);
    errors++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : fail

  // Read results are judged against masked notes
  task automatic cmp_read(input logic [31:0] got, input note_t e);
    n_compared++;
    if ((got & e.mask) !== (e.val & e.mask)) fail($sformatf("read %h want %h", got, e.val));
  endtask : cmp_read

  task automatic cmp_port(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] e);
    n_compared++;
    if (got !== e) fail($sformatf("port %h want %h", got, e));
  endtask : cmp_port

  // Request is held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] v,
                     input logic [3:0] be, input logic [31:0] e, input logic [31:0] m);
    int n;
    n = 0;
    @(posedge clk_sys);
    address    <= {idx, 2'b00};
    read       <= !wr;
    write      <= wr;
    writedata  <= {24'($urandom), v};
    byteenable <= be;
    if (!wr) expq.push_back('{e, m});
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fail("bus hang");
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    bus(1'b1, idx, v, 4'hf, '0, '0);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, idx, 8'h00, 4'hf, e, m);
  endtask : rd

  // One-cycle pulse on drive_start or resonance_update, then settle
  task automatic kick(input logic upd, input logic [CNT_W-1:0] p);
    @(posedge clk_sys);
    resonance_period <= p;
    resonance_update <= upd;
    drive_start      <= !upd;
    @(posedge clk_sys);
    resonance_update <= 1'b0;
    drive_start      <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : kick

  // Monitor takes the oldest note whenever read data is answered
  always @(posedge clk_sys) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (expq.size() == 0) fail("unexpected read");
      else cmp_read(readdata, expq.pop_front());
    end
  end

  // Hang guard well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail("timeout");
      report_and_stop();
    end
  end

  initial begin
    logic [7:0]       rv [5];
    logic [7:0]       sel;
    logic [7:0]       lim;
    logic [1:0]       used;
    logic [4:0]       codes [5];
    logic [1:0]       k;
    logic [CNT_W-1:0] p;
    int               n;
    codes = '{5'd0, 5'd1, 5'd10, 5'd16, 5'd31};
    void'($urandom(32'h5a8aa8c9));
    {reset, read, write, drive_start, resonance_update} = 5'b10000;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'hf;
    cond = '0;
    bemf_valid = 1'b1;
    actuator_present = 1'b1;
    resonance_period = '0;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;

    rd(IDX_RATED_LIMIT, 32'h64, '1);
    rd(IDX_OD_LEVEL_ONE, 32'h80, '1);
    rd(IDX_OD_LEVEL_TWO, 32'h00, '1);
    rd(IDX_PERIOD_CFG, 32'h10, '1);
    rd(IDX_BASE_OD, 32'hff, '1);
    $display("test reset values done");

    // Random write and read back; refused accesses leave values intact
    for (int i = 0; i < 5; i++) begin
      rv[i] = 8'($urandom);
      wr(IDX_RATED_LIMIT + 6'(i), rv[i]);
      rd(IDX_RATED_LIMIT + 6'(i), {24'h0, rv[i]}, '1);
    end
    bus(1'b1, IDX_RATED_LIMIT, ~rv[0], 4'he, '0, '0);
    rd(IDX_RATED_LIMIT, {24'h0, rv[0]}, '1);
    rd(6'h30, 32'h0, '1);
    wr(IDX_CONTROL, 8'h00);
    $display("test register access done");

    // Every combination of the five steering conditions
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_sys);
      cond <= clamp_cond_t'(i[4:0]);
      @(posedge clk_sys);
      if (i[1] || i[0]) sel = rv[4];
      else if (i[2]) sel = rv[2];
      else if (i[3]) sel = rv[1];
      else sel = rv[4];
      lim = i[4] ? sel : ((sel < rv[0]) ? sel : rv[0]);
      used = (i[1] || i[0]) ? 2'b00 : (i[2] ? 2'b10 : {1'b0, i[3]});
      rd(IDX_STATUS, {21'h0, used, 1'b0, lim}, '1);
      cmp_port(CNT_W'(effective_limit), CNT_W'(lim));
    end
    cond <= '0;
    $display("test clamp selection done");

    // Period codes in both modes with all four resync settings
    for (int m = 0; m < 2; m++) begin
      wr(IDX_CONTROL, 8'(m));
      for (int c = 0; c < 5; c++) begin
        k = 2'(c + m);
        wr(IDX_PERIOD_CFG, {k, 1'b0, codes[c]});
        kick(1'b0, '0);
        p = CNT_W'((5 + codes[c]) * STEP * (m + 1));
        cmp_port(drive_period, p);
        cmp_port(resync_interval, k[0] ? p + (p >> 2) : (k[1] ? 24'd90 : 24'd40));
      end
    end
    $display("test period codes done");

    // Tracking of measured resonance and its fall-backs
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_PERIOD_CFG, 8'h50);
    kick(1'b0, '0);
    kick(1'b1, 24'd137);
    cmp_port(drive_period, 24'd137);
    cmp_port(resync_interval, 24'd171);
    cmp_port({23'h0, tracking}, 24'd1);
    kick(1'b1, 24'd0);
    cmp_port(drive_period, 24'd137);
    kick(1'b0, '0);
    cmp_port(drive_period, 24'd84);
    cmp_port({23'h0, tracking}, 24'd0);
    kick(1'b1, 24'd137);
    @(posedge clk_sys);
    bemf_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    cmp_port(drive_period, 24'd84);
    bemf_valid <= 1'b1;
    actuator_present <= 1'b0;
    kick(1'b1, 24'd99);
    cmp_port(drive_period, 24'd84);
    actuator_present <= 1'b1;
    wr(IDX_CONTROL, 8'h01);
    kick(1'b1, 24'd99);
    cmp_port(drive_period, 24'd168);
    $display("test tracking done");

    // Tick spacing follows the back-EMF sample interval
    wr(IDX_PERIOD_CFG, 8'h01);
    kick(1'b0, '0);
    n = 0;
    while (drive_tick !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (drive_tick !== 1'b1 && n < 200);
    cmp_port(CNT_W'(n), 24'd48);
    $display("test drive tick done");
    repeat (4) @(posedge clk_sys);
    report_and_stop();
  end

endmodule : haptic_drive_clamp_timing_tb_top

// ### hw/clamp_timing_pkg.sv
package clamp_timing_pkg;

  // Clock and period arithmetic
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned CLK_HZ           = CLK_MHZ * 1000000;
  localparam int unsigned CNT_W            = 24;
  localparam int unsigned DRIVE_STEP_US    = 100;  // 0.1 ms per code step
  localparam int unsigned DRIVE_STEP_CYC   = DRIVE_STEP_US * CLK_MHZ;
  localparam int unsigned DRIVE_BASE_STEPS = 5;    // Code 0 is 0.5 ms resonant
  localparam int unsigned MIN_FREQ_HIGH_HZ = 125;
  localparam int unsigned MIN_FREQ_LOW_HZ  = 45;
  localparam int unsigned RESYNC_HIGH_CYC  = CLK_HZ / MIN_FREQ_HIGH_HZ;
  localparam int unsigned RESYNC_LOW_CYC   = CLK_HZ / MIN_FREQ_LOW_HZ;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_RATED_LIMIT  = 6'h24;
  localparam logic [5:0] IDX_OD_LEVEL_ONE = 6'h25;
  localparam logic [5:0] IDX_OD_LEVEL_TWO = 6'h26;
  localparam logic [5:0] IDX_PERIOD_CFG   = 6'h27;
  localparam logic [5:0] IDX_BASE_OD      = 6'h28;
  localparam logic [5:0] IDX_CONTROL      = 6'h29;
  localparam logic [5:0] IDX_STATUS       = 6'h2a;

  // Values after reset
  localparam logic [7:0] RATED_LIMIT_RST  = 8'h64;
  localparam logic [7:0] OD_LEVEL_ONE_RST = 8'h80;
  localparam logic [7:0] OD_LEVEL_TWO_RST = 8'h00;
  localparam logic [7:0] PERIOD_CFG_RST   = 8'h10;
  localparam logic [7:0] BASE_OD_RST      = 8'hff;
  localparam logic [7:0] CONTROL_RST      = 8'h00;

  // Field positions
  localparam int unsigned CTRL_ECCENTRIC_BIT = 0;
  localparam int unsigned STAT_LIMIT_LSB     = 0;
  localparam int unsigned STAT_TRACK_BIT     = 8;
  localparam int unsigned STAT_LVL1_BIT      = 9;
  localparam int unsigned STAT_LVL2_BIT      = 10;

  // Layout of the resonance and drive-period register
  typedef struct packed {
    logic       lowest_resonance_select;
    logic       resync_timing_select;
    logic       reserved_bit;
    logic [4:0] drive_period_code;
  } period_cfg_t;

  // Conditions that steer the clamp choice
  typedef struct packed {
    logic overdrive_phase;
    logic battery_threshold_one;
    logic battery_threshold_two;
    logic calibration_active;
    logic diagnostic_active;
  } clamp_cond_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avmm_req_t;

endpackage : clamp_timing_pkg

// ### hw/drive_period_timer.sv
`timescale 1ns/1ns
module drive_period_timer
  import clamp_timing_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] period,
  output logic                  tick
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic             tick_r;
  logic             tick_nxt;

  // Period counter; a period of zero or one ticks every cycle
  always_comb begin
    count_nxt = count_r + WIDTH'(1);
    tick_nxt  = 1'b0;
    if (restart) begin
      count_nxt = '0;
    end else if (count_r + WIDTH'(1) >= period) begin
      count_nxt = '0;
      tick_nxt  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_r <= '0;
      tick_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick_r  <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule : drive_period_timer

// ### hw/haptic_drive_clamp_timing.sv
`timescale 1ns/1ns
module haptic_drive_clamp_timing
  import clamp_timing_pkg::*;
#(
  parameter int unsigned STEP_CYCLES   = DRIVE_STEP_CYC,
  parameter int unsigned RESYNC_HIGH   = RESYNC_HIGH_CYC,
  parameter int unsigned RESYNC_LOW    = RESYNC_LOW_CYC,
  parameter logic [7:0]  BASE_OD_RESET = BASE_OD_RST
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [7:0]       address,
  input  wire logic             read,
  input  wire logic             write,
  input  wire logic [31:0]      writedata,
  input  wire logic [3:0]       byteenable,
  output logic [31:0]           readdata,
  output logic                  waitrequest,
  input  wire logic             overdrive_phase,
  input  wire logic             battery_threshold_one,
  input  wire logic             battery_threshold_two,
  input  wire logic             calibration_active,
  input  wire logic             diagnostic_active,
  input  wire logic             drive_start,
  input  wire logic             bemf_valid,
  input  wire logic             actuator_present,
  input  wire logic             resonance_update,
  input  wire logic [CNT_W-1:0] resonance_period,
  output logic [7:0]            effective_limit,
  output logic [CNT_W-1:0]      drive_period,
  output logic [CNT_W-1:0]      resync_interval,
  output logic                  drive_tick,
  output logic                  tracking
);

  // Period in cycles for a code; eccentric mode doubles the time
  function automatic logic [CNT_W-1:0] code_cycles(input logic [4:0] code,
                                                   input logic       eccentric);
    logic [CNT_W-1:0] base;
    base = CNT_W'((DRIVE_BASE_STEPS + 32'(code)) * STEP_CYCLES);
    return eccentric ? CNT_W'({base, 1'b0}) : base;
  endfunction : code_cycles

  function automatic logic [7:0] lower_of(input logic [7:0] a, input logic [7:0] b);
    return (a < b) ? a : b;
  endfunction : lower_of

  avmm_req_t   req;
  clamp_cond_t cond;
  assign req  = '{address, read, write, writedata, byteenable};
  assign cond = '{overdrive_phase, battery_threshold_one, battery_threshold_two,
                  calibration_active, diagnostic_active};

  // Register file and bus slave
  logic [7:0]  rated_r, rated_nxt;
  logic [7:0]  lvl1_r, lvl1_nxt;
  logic [7:0]  lvl2_r, lvl2_nxt;
  logic [7:0]  base_r, base_nxt;
  logic [7:0]  ctrl_r, ctrl_nxt;
  period_cfg_t pcfg_r, pcfg_nxt;
  logic        wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [5:0]  index;
  logic        aligned;
  logic        accept;
  logic        lvl1_used_r, lvl2_used_r;
  logic [7:0]  limit_r, limit_nxt;
  logic        track_r, track_nxt;

  assign index   = req.address[7:2];
  assign aligned = (req.address[1:0] == 2'b00);
  // The request is taken at the edge where waitrequest is seen low
  assign accept  = (req.read | req.write) & ~wait_r;

  // Waitrequest drops for one cycle, one cycle after the request shows
  always_comb begin
    wait_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    rated_nxt = rated_r;
    lvl1_nxt  = lvl1_r;
    lvl2_nxt  = lvl2_r;
    base_nxt  = base_r;
    ctrl_nxt  = ctrl_r;
    pcfg_nxt  = pcfg_r;
    if ((req.read | req.write) & wait_r) begin
      wait_nxt  = 1'b0;
      rdata_nxt = 32'h0000_0000; // Unmapped or misaligned reads answer zero
      if (req.read & aligned) begin
        unique case (index)
          IDX_RATED_LIMIT:  rdata_nxt[7:0] = rated_r;
          IDX_OD_LEVEL_ONE: rdata_nxt[7:0] = lvl1_r;
          IDX_OD_LEVEL_TWO: rdata_nxt[7:0] = lvl2_r;
          IDX_PERIOD_CFG:   rdata_nxt[7:0] = pcfg_r;
          IDX_BASE_OD:      rdata_nxt[7:0] = base_r;
          IDX_CONTROL:      rdata_nxt[7:0] = ctrl_r;
          IDX_STATUS: begin
            rdata_nxt[STAT_LIMIT_LSB +: 8] = limit_r;
            rdata_nxt[STAT_TRACK_BIT]      = track_r;
            rdata_nxt[STAT_LVL1_BIT]       = lvl1_used_r;
            rdata_nxt[STAT_LVL2_BIT]       = lvl2_used_r;
          end
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    // Only the low byte lane carries data; other lanes are ignored
    if (accept & req.write & aligned & req.byteenable[0]) begin
      unique case (index)
        IDX_RATED_LIMIT:  rated_nxt = req.writedata[7:0];
        IDX_OD_LEVEL_ONE: lvl1_nxt  = req.writedata[7:0];
        IDX_OD_LEVEL_TWO: lvl2_nxt  = req.writedata[7:0];
        IDX_PERIOD_CFG:   pcfg_nxt  = req.writedata[7:0];
        IDX_BASE_OD:      base_nxt  = req.writedata[7:0];
        IDX_CONTROL:      ctrl_nxt  = {7'h00, req.writedata[CTRL_ECCENTRIC_BIT]};
        default:          ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
      rated_r <= RATED_LIMIT_RST;
      lvl1_r  <= OD_LEVEL_ONE_RST;
      lvl2_r  <= OD_LEVEL_TWO_RST;
      base_r  <= BASE_OD_RESET;
      ctrl_r  <= CONTROL_RST;
      pcfg_r  <= PERIOD_CFG_RST;
    end else begin
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
      rated_r <= rated_nxt;
      lvl1_r  <= lvl1_nxt;
      lvl2_r  <= lvl2_nxt;
      base_r  <= base_nxt;
      ctrl_r  <= ctrl_nxt;
      pcfg_r  <= pcfg_nxt;
    end
  end

  // Clamp selection
  logic       eccentric;
  logic       battery_ok;
  logic [7:0] od_sel;
  logic       lvl1_used_nxt, lvl2_used_nxt;

  assign eccentric  = ctrl_r[CTRL_ECCENTRIC_BIT];
  // Battery levels are meaningless while calibrating or diagnosing
  assign battery_ok = ~(cond.calibration_active | cond.diagnostic_active);

  // Level two outranks level one, which outranks the base limit
  always_comb begin
    od_sel        = base_r;
    lvl1_used_nxt = 1'b0;
    lvl2_used_nxt = 1'b0;
    if (battery_ok & cond.battery_threshold_two) begin
      od_sel        = lvl2_r;
      lvl2_used_nxt = 1'b1;
    end else if (battery_ok & cond.battery_threshold_one) begin
      od_sel        = lvl1_r;
      lvl1_used_nxt = 1'b1;
    end
    // Steady state takes the rated limit unless the other is lower
    limit_nxt = cond.overdrive_phase ? od_sel : lower_of(rated_r, od_sel);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      limit_r     <= 8'h00;
      lvl1_used_r <= 1'b0;
      lvl2_used_r <= 1'b0;
    end else begin
      limit_r     <= limit_nxt;
      lvl1_used_r <= lvl1_used_nxt;
      lvl2_used_r <= lvl2_used_nxt;
    end
  end

  // Drive period, tracking and resync
  logic [CNT_W-1:0] period_r, period_nxt;
  logic [CNT_W-1:0] resync_r, resync_nxt;
  logic [CNT_W-1:0] code_per;
  logic             track_ok;

  assign code_per = code_cycles(pcfg_r.drive_period_code, eccentric);
  assign track_ok = ~eccentric & bemf_valid & actuator_present;

  // Code seeds the period; measured resonance refines it afterwards
  always_comb begin
    track_nxt  = track_r & track_ok;
    period_nxt = period_r;
    if (drive_start | ~track_ok) begin
      period_nxt = code_per;
      track_nxt  = 1'b0;
    end else if (resonance_update && resonance_period != '0) begin
      period_nxt = resonance_period;
      track_nxt  = 1'b1;
    end
    // Resync from the lowest frequency, or from 1.25 times the period
    if (pcfg_r.resync_timing_select) begin
      resync_nxt = period_r + (period_r >> 2);
    end else if (pcfg_r.lowest_resonance_select) begin
      resync_nxt = CNT_W'(RESYNC_LOW);
    end else begin
      resync_nxt = CNT_W'(RESYNC_HIGH);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      period_r <= '0;
      resync_r <= '0;
      track_r  <= 1'b0;
    end else begin
      period_r <= period_nxt;
      resync_r <= resync_nxt;
      track_r  <= track_nxt;
    end
  end

  // Ticks drive half-cycles, or back-EMF samples in eccentric mode
  drive_period_timer #(
    .WIDTH (CNT_W)
  ) u_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .restart (drive_start),
    .period  (period_r),
    .tick    (drive_tick)
  );

  assign readdata        = rdata_r;
  assign waitrequest     = wait_r;
  assign effective_limit = limit_r;
  assign drive_period    = period_r;
  assign resync_interval = resync_r;
  assign tracking        = track_r;

  // Assertions
  sequence bus_req_s;
    (read | write) && waitrequest;
  endsequence
  sequence bus_ans_s;
    !waitrequest ##1 waitrequest;
  endsequence

  bus_answer_a: assert property (@(posedge clk_sys) disable iff (reset)
    bus_req_s |=> bus_ans_s)
    else $error("bus answer not given in one cycle");
  steady_limit_a: assert property (@(posedge clk_sys) disable iff (reset)
    !overdrive_phase |=> effective_limit <= $past(rated_r))
    else $error("steady limit above rated limit");
  lower_wins_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!overdrive_phase && !battery_threshold_one && !battery_threshold_two)
    |=> effective_limit == lower_of($past(rated_r), $past(base_r)))
    else $error("lower limit not applied");
  level_one_a: assert property (@(posedge clk_sys) disable iff (reset)
    (overdrive_phase && battery_threshold_one && !battery_threshold_two && battery_ok)
    |=> effective_limit == $past(lvl1_r) && lvl1_used_r)
    else $error("level one limit not used");
  level_two_a: assert property (@(posedge clk_sys) disable iff (reset)
    (overdrive_phase && battery_threshold_two && battery_ok)
    |=> effective_limit == $past(lvl2_r) && lvl2_used_r && !lvl1_used_r)
    else $error("level two limit not used");
  calib_ignore_a: assert property (@(posedge clk_sys) disable iff (reset)
    (overdrive_phase && (calibration_active || diagnostic_active))
    |=> effective_limit == $past(base_r))
    else $error("battery level used during calibration");
  min_freq_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!pcfg_r.resync_timing_select && pcfg_r.lowest_resonance_select)
    |=> resync_interval == CNT_W'(RESYNC_LOW))
    else $error("low frequency resync interval wrong");
  resync_scaled_a: assert property (@(posedge clk_sys) disable iff (reset)
    pcfg_r.resync_timing_select
    |=> resync_interval == $past(period_r) + ($past(period_r) >> 2))
    else $error("scaled resync interval wrong");
  start_estimate_a: assert property (@(posedge clk_sys) disable iff (reset)
    (drive_start && !eccentric) ##1 (!drive_start && !resonance_update && track_ok)
    |-> drive_period == $past(code_per, 1))
    else $error("period not seeded from code");
  tracking_a: assert property (@(posedge clk_sys) disable iff (reset)
    (track_ok && !drive_start && resonance_update && resonance_period != '0)
    |=> drive_period == $past(resonance_period) && tracking)
    else $error("period did not follow resonance");
  free_run_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!eccentric && (!bemf_valid || !actuator_present))
    |=> drive_period == $past(code_per) && !tracking)
    else $error("free-running period wrong");
  erm_sample_a: assert property (@(posedge clk_sys) disable iff (reset)
    eccentric |=> drive_period ==
      CNT_W'(2 * (DRIVE_BASE_STEPS + 32'($past(pcfg_r.drive_period_code))) * STEP_CYCLES))
    else $error("eccentric sample interval wrong");

endmodule : haptic_drive_clamp_timing
